// ---- rtl/static_table_regs_pkg.sv ----
// Constants for the static table access, port tag and wake event register slice.
// Assumes a 16-bit byte address bus with 32-bit data and one core clock.
package static_table_regs_pkg;
  // Global register offsets
  localparam logic [15:0] CTRL_OFS       = 16'h041C;
  localparam logic [15:0] ENTRY1_OFS     = 16'h0420;
  localparam logic [15:0] ENTRY2_OFS     = 16'h0424;
  localparam logic [15:0] ENTRY3_OFS     = 16'h0428;
  localparam logic [15:0] ENTRY4_OFS     = 16'h042C;
  localparam logic [15:0] INT_STATUS_OFS = 16'h0500;
  localparam logic [15:0] INT_MASK_OFS   = 16'h0504;
  // Per-port window: port number in the top nibble, offset in the low byte
  localparam logic [3:0]  PORT_PAGE      = 4'h0;
  localparam logic [7:0]  TAG_HIGH_OFS   = 8'h00;
  localparam logic [7:0]  TAG_LOW_OFS    = 8'h01;
  localparam logic [7:0]  WAKE_OFS       = 8'h13;
  localparam int          NUM_PORTS      = 3;
  localparam logic [2:0]  PHY_PORT_MASK  = 3'h3;
  // Control register fields
  localparam int          GO_BIT         = 7;
  localparam int          SEL_BIT        = 1;
  localparam int          ACT_BIT        = 0;
  localparam int          IDX_LSB        = 16;
  localparam int          IDX_W          = 6;
  localparam int          STATIC_IDX_W   = 4;
  localparam int          RSV_LSB        = 2;
  localparam int          RSV_W          = 5;
  localparam logic        SEL_MCAST      = 1'h1;
  localparam logic        ACT_READ       = 1'h1;
  localparam int          MCAST_WORD     = 1;
  localparam int          ENTRY_WORDS    = 4;
  // Default tag fields and reset values
  localparam int          PCP_LSB        = 5;
  localparam int          DEI_BIT        = 4;
  localparam logic [7:0]  TAG_HIGH_RESET = 8'h00;
  localparam logic [7:0]  TAG_LOW_RESET  = 8'h01;
  // Wake event bits
  localparam int          WAKE_PAT_BIT   = 2;
  localparam int          WAKE_LINK_BIT  = 1;
  localparam int          WAKE_NRG_BIT   = 0;
  localparam int          WAKE_W         = 3;
  // Interrupt status layout
  localparam int          INT_DONE_BIT   = 0;
  localparam int          INT_WAKE_LSB   = 1;
  localparam int          INT_W          = 4;
  // Access engine states
  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } access_state_type;
endpackage

// ---- rtl/static_table_access_port_tag_wake_regs.sv ----
// Register slice: indirect static/multicast table access, per-port default tags,
// per-port wake event flags and a small interrupt block.
// Assumes the table engine runs on mclk; link and energy levels come from PHY logic
// in another domain and are synchronised here.
//
// Functional notes
// - Multicast table uses index bits 21:16.
// - Static table uses index bits 19:16.
// - Go bit starts access, clears itself.
// - Bit 1 selects multicast or static table.
// - Bit 0 selects read or write.
// - Static entries move through all four words.
// - Multicast entries move through word two only.
// - Entry word layout depends on table.
// - Port number in address top nibble.
// - Transceiver registers only on ports one, two.
// - Tag high byte holds PCP, DEI, VID high.
// - Tag low byte VID low, resets one.
// - Bit two flags wake pattern frame.
// - Bit one flags link-up, transceiver ports.
// - Bit zero flags cable energy, transceiver ports.
// - MAC-only port link/energy flags read zero.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module static_table_access_port_tag_wake_regs
  import static_table_regs_pkg::*;
(
  input  wire logic                   mclk,           // Core clock, 10 MHz
  input  wire logic                   rst_n,          // Synchronous reset
  input  wire logic [15:0]            addr,           // Register byte address
  input  wire logic [31:0]            wdata,          // Write data
  input  wire logic                   wr,             // Write strobe
  input  wire logic                   rd,             // Read strobe
  output logic      [31:0]            rdata,          // Read data, cycle after rd
  output logic                        irq,            // Level interrupt
  output logic                        eng_req,        // Table access request
  output logic                        eng_table_sel,  // 1 = multicast table
  output logic                        eng_read,       // 1 = read access
  output logic      [IDX_W-1:0]       eng_index,      // Entry address
  output logic      [31:0]            eng_wdata1,     // Entry word 1 to table
  output logic      [31:0]            eng_wdata2,     // Entry word 2 to table
  output logic      [31:0]            eng_wdata3,     // Entry word 3 to table
  output logic      [31:0]            eng_wdata4,     // Entry word 4 to table
  input  wire logic                   eng_ack,        // Access done pulse
  input  wire logic [31:0]            eng_rdata1,     // Entry word 1 from table
  input  wire logic [31:0]            eng_rdata2,     // Entry word 2 from table
  input  wire logic [31:0]            eng_rdata3,     // Entry word 3 from table
  input  wire logic [31:0]            eng_rdata4,     // Entry word 4 from table
  input  wire logic [NUM_PORTS-1:0]   wake_pattern,   // Pattern frame seen, pulse
  input  wire logic [NUM_PORTS-1:0]   link_up,        // Link up level, async
  input  wire logic [NUM_PORTS-1:0]   energy_seen,    // Cable energy level, async
  output logic      [NUM_PORTS*12-1:0] port_vid,      // Default VLAN id per port
  output logic      [NUM_PORTS*3-1:0] port_pcp,       // Default priority per port
  output logic      [NUM_PORTS-1:0]   port_dei,       // Default drop eligible
  output logic      [NUM_PORTS*WAKE_W-1:0] wake_event // Flags to wake logic
);

  // Bus decode, access engine and per-port storage all run on mclk; only
  // the link and energy levels arrive from elsewhere and are synchronised.
  // Access state and control fields
  access_state_type              state;        // Go bit reads one while busy
  logic             [IDX_W-1:0]  table_index;  // Shared index field
  logic             [RSV_W-1:0]  ctrl_rsv;     // Spare read/write bits
  logic                          table_sel;    // Target table
  logic                          action;       // Read or write
  logic             [31:0]       entry [ENTRY_WORDS]; // Shared entry words
  // Index 0 is port 1; index 2 is the MAC-only port
  // Per-port storage
  logic             [7:0]        tag_high [NUM_PORTS];
  logic             [7:0]        tag_low  [NUM_PORTS];
  logic             [WAKE_W-1:0] wake     [NUM_PORTS];
  // Two stages per bit; only the second stage is read by any logic
  // Synchronisers for PHY levels
  logic             [NUM_PORTS-1:0] link_meta;
  logic             [NUM_PORTS-1:0] link_sync;
  logic             [NUM_PORTS-1:0] nrg_meta;
  logic             [NUM_PORTS-1:0] nrg_sync;
  // Status bit 0 is access done, bits 3:1 one per port
  // Interrupt block
  logic             [INT_W-1:0]  int_status;
  logic             [INT_W-1:0]  int_mask;
  logic             [INT_W-1:0]  int_events;
  // Decode
  logic                          busy;
  logic                          ctrl_wr;
  logic             [NUM_PORTS-1:0] port_hit;
  logic             [31:0]       next_rdata;
  logic             [WAKE_W-1:0] wake_set [NUM_PORTS];

  assign busy    = (state == ST_BUSY);
  assign ctrl_wr = wr && (addr == CTRL_OFS);

  // Ports are numbered from one on the bus and from zero inside this module.
  // Pages other than zero belong to other register groups and are ignored.
  // Port window decode: top nibble is the port, page nibble must be zero
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_hit[p] = (addr[15:12] == 4'(p + 1)) && (addr[11:8] == PORT_PAGE);
    end
  end

  // Levels only: a pulse shorter than one clock may be missed, which is
  // acceptable because link and energy states last far longer than that.
  // Reset clears both stages so no stale level raises a flag after reset.
  // Two-flop synchronisers for the PHY link and energy levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_meta <= '0;
      link_sync <= '0;
      nrg_meta  <= '0;
      nrg_sync  <= '0;
    end else begin
      link_meta <= link_up;
      link_sync <= link_meta;
      nrg_meta  <= energy_seen;
      nrg_sync  <= nrg_meta;
    end
  end

  // There is no timeout: an engine that never answers leaves go set, and
  // software can only recover by a reset of the whole slice.
  // A go write while busy is ignored rather than queued.
  // Access state: software raises go, the engine ack drops it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // New access only taken from idle
          if (ctrl_wr && wdata[GO_BIT]) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // Self-clear once the table reports completion
          if (eng_ack) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // The go bit itself is not stored here; it is the busy state above.
  // Reserved bits 31:22 and 15:8 are not stored and read back as zero.
  // Control fields; frozen while busy so the engine sees stable values
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      table_index <= '0;
      ctrl_rsv    <= '0;
      table_sel   <= 1'h0;
      action      <= 1'h0;
    end else if (ctrl_wr && !busy) begin
      table_index <= wdata[IDX_LSB +: IDX_W];
      ctrl_rsv    <= wdata[RSV_LSB +: RSV_W];
      table_sel   <= wdata[SEL_BIT];
      action      <= wdata[ACT_BIT];
    end
  end

  // Writes during an access are dropped so the engine never sees a word
  // change under it; software must wait for go to read zero first.
  // Write accesses leave all four words as software loaded them.
  // Entry words: software loads while idle, engine read data on completion
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int w = 0; w < ENTRY_WORDS; w++) begin
        entry[w] <= '0;
      end
    end else if (busy) begin
      // Read result lands on the same edge the go bit clears
      if (eng_ack && (action == ACT_READ)) begin
        if (table_sel == SEL_MCAST) begin
          // Other words keep their contents for multicast reads
          entry[MCAST_WORD] <= eng_rdata2;
        end else begin
          entry[0] <= eng_rdata1;
          entry[1] <= eng_rdata2;
          entry[2] <= eng_rdata3;
          entry[3] <= eng_rdata4;
        end
      end
    end else if (wr) begin
      // Raw words; field meaning is up to the selected table
      if (addr == ENTRY1_OFS) entry[0] <= wdata;
      if (addr == ENTRY2_OFS) entry[1] <= wdata;
      if (addr == ENTRY3_OFS) entry[2] <= wdata;
      if (addr == ENTRY4_OFS) entry[3] <= wdata;
    end
  end

  // Only muxing on table_sel sits after the flops, so these stay stable for
  // the whole access because every source is frozen while busy.
  // Engine request side, all from flops
  always_comb begin
    eng_req       = busy;
    eng_table_sel = table_sel;
    eng_read      = action;
    // Static table sees only the low index bits
    if (table_sel == SEL_MCAST) begin
      eng_index = table_index;
    end else begin
      eng_index = {{(IDX_W - STATIC_IDX_W){1'h0}}, table_index[STATIC_IDX_W-1:0]};
    end
    // Multicast writes carry word two only; others are held at zero
    if (table_sel == SEL_MCAST) begin
      eng_wdata1 = '0;
      eng_wdata2 = entry[MCAST_WORD];
      eng_wdata3 = '0;
      eng_wdata4 = '0;
    end else begin
      eng_wdata1 = entry[0];
      eng_wdata2 = entry[1];
      eng_wdata3 = entry[2];
      eng_wdata4 = entry[3];
    end
  end

  // Byte-wide registers: only wdata[7:0] is used and the rest ignored.
  // Tags stay writable during a table access; they have no link to it.
  // Default tag registers per port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        tag_high[p] <= TAG_HIGH_RESET;
        tag_low[p]  <= TAG_LOW_RESET;
      end
    end else if (wr) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_hit[p] && addr[7:0] == TAG_HIGH_OFS) tag_high[p] <= wdata[7:0];
        if (port_hit[p] && addr[7:0] == TAG_LOW_OFS)  tag_low[p]  <= wdata[7:0];
      end
    end
  end

  // The VLAN id spans both bytes: high nibble from tag_high, low byte from
  // tag_low, so a new id takes two writes and is briefly mixed between them.
  // Split tags into their fields for the forwarding logic
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_pcp[p*3 +: 3]  = tag_high[p][PCP_LSB +: 3];
      port_dei[p]         = tag_high[p][DEI_BIT];
      port_vid[p*12 +: 12] = {tag_high[p][3:0], tag_low[p]};
    end
  end

  // Pattern pulses come from frame logic on mclk and need no synchroniser.
  // The MAC-only port has its link and energy inputs ignored entirely.
  // Wake event sources; link and energy gated to transceiver ports
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      wake_set[p]                = '0;
      wake_set[p][WAKE_PAT_BIT]  = wake_pattern[p];
      wake_set[p][WAKE_LINK_BIT] = link_sync[p] && PHY_PORT_MASK[p];
      wake_set[p][WAKE_NRG_BIT]  = nrg_sync[p] && PHY_PORT_MASK[p];
    end
  end

  // A source still high keeps setting its flag, so a clear only sticks
  // once the condition has gone away.
  // Sticky wake flags; write-one clears, a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        wake[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wr && port_hit[p] && addr[7:0] == WAKE_OFS) begin
          wake[p] <= (wake[p] & ~wdata[WAKE_W-1:0]) | wake_set[p];
        end else begin
          wake[p] <= wake[p] | wake_set[p];
        end
      end
    end
  end

  // Masking here as well keeps the MAC port's unused bits at zero even if
  // the source gating above were ever changed.
  // Flags to the wake signalling logic
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      wake_event[p*WAKE_W +: WAKE_W] = wake[p] & {1'h1, {2{PHY_PORT_MASK[p]}}};
    end
  end

  // One status bit per port, not per flag; the flag register tells which.
  // Interrupt events: access done plus any wake flag per port
  always_comb begin
    int_events               = '0;
    int_events[INT_DONE_BIT] = busy && eng_ack;
    for (int p = 0; p < NUM_PORTS; p++) begin
      int_events[INT_WAKE_LSB + p] = |wake_set[p];
    end
  end

  // Clearing on read means a second read of the status returns only the
  // events that arrived in between.
  // Sticky status, cleared by reading it; a same-cycle event survives
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_status <= '0;
    end else if (rd && addr == INT_STATUS_OFS) begin
      int_status <= int_events;
    end else begin
      int_status <= int_status | int_events;
    end
  end

  // Mask resets to zero so irq stays low until software enables it.
  // Mask register, one enables a status bit onto irq
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_mask <= '0;
    end else if (wr && addr == INT_MASK_OFS) begin
      int_mask <= wdata[INT_W-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(int_status & int_mask);

  // Global offsets are matched first; anything else falls to the port window.
  // Bits above a register's width always read zero.
  // Read data selection; unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    unique case (addr)
      CTRL_OFS: begin
        next_rdata[IDX_LSB +: IDX_W] = table_index;
        next_rdata[GO_BIT]           = busy;
        next_rdata[RSV_LSB +: RSV_W] = ctrl_rsv;
        next_rdata[SEL_BIT]          = table_sel;
        next_rdata[ACT_BIT]          = action;
      end
      ENTRY1_OFS:     next_rdata = entry[0];
      ENTRY2_OFS:     next_rdata = entry[1];
      ENTRY3_OFS:     next_rdata = entry[2];
      ENTRY4_OFS:     next_rdata = entry[3];
      INT_STATUS_OFS: next_rdata[INT_W-1:0] = int_status;
      INT_MASK_OFS:   next_rdata[INT_W-1:0] = int_mask;
      default: begin
        // Per-port window
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (port_hit[p]) begin
            if (addr[7:0] == TAG_HIGH_OFS) next_rdata[7:0] = tag_high[p];
            if (addr[7:0] == TAG_LOW_OFS)  next_rdata[7:0] = tag_low[p];
            if (addr[7:0] == WAKE_OFS) begin
              next_rdata[WAKE_W-1:0] = wake_event[p*WAKE_W +: WAKE_W];
            end
          end
        end
      end
    endcase
  end

  // Returning to zero between reads keeps stale data off the bus.
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// ---- verif/static_table_regs_chk.sv ----
// Checker for the table access, port tag and wake register slice.
// Assumes a bind onto the slice; it sees the slice's ports only.
`timescale 1ns/1ps
`default_nettype none
module static_table_regs_chk
  import static_table_regs_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire logic [15:0]                 addr,
  input wire logic [31:0]                 wdata,
  input wire logic                        wr,
  input wire logic                        eng_req,
  input wire logic                        eng_table_sel,
  input wire logic [IDX_W-1:0]            eng_index,
  input wire logic [31:0]                 eng_wdata1,
  input wire logic [31:0]                 eng_wdata3,
  input wire logic [31:0]                 eng_wdata4,
  input wire logic                        eng_ack,
  input wire logic [NUM_PORTS-1:0]        wake_pattern,
  input wire logic [NUM_PORTS-1:0]        link_up,
  input wire logic [NUM_PORTS*12-1:0]     port_vid,
  input wire logic [NUM_PORTS*3-1:0]      port_pcp,
  input wire logic [NUM_PORTS-1:0]        port_dei,
  input wire logic [NUM_PORTS*WAKE_W-1:0] wake_event
);
  // Start from idle; a start while busy is refused, so idle is required
  logic start;
  assign start = wr && addr == CTRL_OFS && wdata[GO_BIT] && !eng_req;

  // All checks on the core clock, quiet during reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_go_starts_req:
  assert property (start |=> eng_req) else $error("request did not rise");
  a_ack_ends_req:
  assert property (eng_req && eng_ack |=> !eng_req) else $error("request outlived ack");
  a_mcast_index:
  assert property (start && wdata[SEL_BIT] |=> eng_index == $past(wdata[21:16]))
    else $error("multicast index wrong");
  a_static_index:
  assert property (start && !wdata[SEL_BIT] |=> eng_index == {2'h0, $past(wdata[19:16])})
    else $error("static index wrong");
  a_mcast_words:
  assert property (eng_req && eng_table_sel |-> (eng_wdata1 | eng_wdata3 | eng_wdata4) == 32'h0)
    else $error("unused entry words driven");
  a_mac_port_quiet:
  assert property (wake_event[7:6] == 2'h0) else $error("MAC port link or energy flag set");
  a_pattern_sets_flag:
  assert property (wake_pattern[0] |=> wake_event[WAKE_PAT_BIT]) else $error("pattern lost");
  a_link_sets_flag:
  assert property (link_up[0] [*3] |=> wake_event[WAKE_LINK_BIT]) else $error("link lost");
  a_tag_high_fields:
  assert property (wr && addr == 16'h1000 |=> port_pcp[2:0] == $past(wdata[7:5])
    && port_dei[0] == $past(wdata[4]) && port_vid[11:8] == $past(wdata[3:0]))
    else $error("tag high fields wrong");
endmodule
bind static_table_access_port_tag_wake_regs static_table_regs_chk chk (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .eng_req(eng_req),
  .eng_table_sel(eng_table_sel), .eng_index(eng_index), .eng_wdata1(eng_wdata1),
  .eng_wdata3(eng_wdata3), .eng_wdata4(eng_wdata4), .eng_ack(eng_ack),
  .wake_pattern(wake_pattern), .link_up(link_up), .port_vid(port_vid),
  .port_pcp(port_pcp), .port_dei(port_dei), .wake_event(wake_event)
);
`default_nettype wire

// ---- verif/test_static_table_access_port_tag_wake_regs.sv ----
// Self-checking bench for the table access, port tag and wake register slice.
// Assumes the bench is both bus master and table engine.
`timescale 1ns/1ps
`default_nettype none
module test_static_table_access_port_tag_wake_regs
  import static_table_regs_pkg::*;
;
  logic         mclk, rst_n, wr, rd, ack, irq, req, sel, rdop; // Clock, strobes, engine
  logic [5:0]   idx;                                 // Engine entry address
  logic [15:0]  addr;                                // Bus address
  logic [31:0]  wdata, rdata, v, ctl, r1, r2, r3, r4, w1, w2, w3, w4; // Data
  logic [31:0]  ent [4];                             // Expected entry words
  logic [127:0] ew;                                  // Expected engine words
  logic [2:0]   pat, lnk, nrg, dei;                  // Wake sources, drop eligible
  logic [8:0]   pcp, wev;                            // Priorities, wake flags
  logic [35:0]  vid;                                 // Default VLAN ids
  int           miscompares, tests_run, cycles;      // Verdict counters

  static_table_access_port_tag_wake_regs uut (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .eng_req(req), .eng_table_sel(sel), .eng_read(rdop), .eng_index(idx),
    .eng_wdata1(w1), .eng_wdata2(w2), .eng_wdata3(w3), .eng_wdata4(w4), .eng_ack(ack),
    .eng_rdata1(r1), .eng_rdata2(r2), .eng_rdata3(r3), .eng_rdata4(r4), .wake_pattern(pat),
    .link_up(lnk), .energy_seen(nrg), .port_vid(vid), .port_pcp(pcp), .port_dei(dei),
    .wake_event(wev)
  );

  // 100 ns core clock
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // Verdict, the one exit
  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare and count
  task automatic check(input string nm, input logic [127:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask

  // One-cycle read strobe; data stand only in the next cycle
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1 check($sformatf("register %h", a), exp, rdata);
  endtask

  // Entry address the engine should see
  function automatic logic [5:0] exp_index(input logic [31:0] c);
    return c[SEL_BIT] ? c[21:16] : {2'h0, c[19:16]};
  endfunction

  // Transceiver ports raise all three flags, the MAC port only the pattern flag
  function automatic logic [2:0] exp_wake(input int p);
    return (p == NUM_PORTS - 1) ? 3'h4 : 3'h7;
  endfunction

  initial begin
    {rst_n, wr, rd, ack, pat, lnk, nrg, addr, wdata, r1, r2, r3, r4} = '0;
    v = $urandom(32'h55C0);
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    rd_chk(CTRL_OFS, 32'h0);
    check("port_vid", {3{12'h001}}, vid);
    rd_chk(16'h0400, 32'h0);
    rd_chk(16'h4000, 32'h0);
    rd_chk(16'h1100, 32'h0);
    // Tags: reset values, random fields, readback
    for (int p = 1; p <= NUM_PORTS; p++) begin
      rd_chk({4'(p), 12'h000}, TAG_HIGH_RESET);
      rd_chk({4'(p), 12'h001}, TAG_LOW_RESET);
      v = $urandom;
      wr_reg({4'(p), 12'h000}, v >> 8);
      wr_reg({4'(p), 12'h001}, v);
      #1 check("port_vid", v[11:0], vid[12*(p-1) +: 12]);
      check("port_pcp", v[15:13], pcp[3*(p-1) +: 3]);
      check("port_dei", v[12], dei[p-1]);
      rd_chk({4'(p), 12'h000}, v[15:8]);
    end
    // Every table and direction; full index first, then random
    for (int i = 0; i < 8; i++) begin
      foreach (ent[k]) ent[k] = $urandom;
      foreach (ent[k]) wr_reg(ENTRY1_OFS + 16'(4 * k), ent[k]);
      ctl = {10'h0, (i < 4) ? 6'h3F : 6'($urandom), 8'h0, 1'h1, 5'($urandom), i[1], i[0]};
      ew = ctl[1] ? {32'h0, ent[1], 64'h0} : {ent[0], ent[1], ent[2], ent[3]};
      wr_reg(CTRL_OFS, ctl);
      #1 check("eng_req", 1, req);
      check("eng_index", exp_index(ctl), idx);
      check("eng_table_sel", ctl[1], sel);
      check("eng_read", ctl[0], rdop);
      check("eng_wdata", ew, {w1, w2, w3, w4});
      // Write while busy must be dropped
      wr_reg(ENTRY1_OFS, ~ent[0]);
      rd_chk(CTRL_OFS, ctl);
      repeat ($urandom % 4) @(posedge mclk);
      @(posedge mclk);
      {r1, r2, r3, r4} <= {$urandom, $urandom, $urandom, $urandom};
      ack <= 1'h1;
      @(posedge mclk);
      ack <= 1'h0;
      #1 check("eng_req", 0, req);
      if (ctl[0] && ctl[1]) ent[1] = r2;
      else if (ctl[0]) ent = '{r1, r2, r3, r4};
      foreach (ent[k]) rd_chk(ENTRY1_OFS + 16'(4 * k), ent[k]);
      rd_chk(CTRL_OFS, ctl & ~32'h80);
      rd_chk(INT_STATUS_OFS, 32'h1);
    end
    // Wake flags, clear by write, status and interrupt per port
    wr_reg(INT_MASK_OFS, 32'hE);
    for (int p = 0; p < NUM_PORTS; p++) begin
      @(posedge mclk);
      {pat[p], lnk[p], nrg[p]} <= 3'h7;
      @(posedge mclk);
      pat[p] <= 1'h0;
      repeat (3) @(posedge mclk);
      {lnk[p], nrg[p]} <= 2'h0;
      #1 check("wake_event", exp_wake(p), wev[3*p +: 3]);
      check("irq", 1, irq);
      wr_reg(INT_MASK_OFS, 32'h0);
      #1 check("irq", 0, irq);
      wr_reg(INT_MASK_OFS, 32'hE);
      rd_chk({4'(p + 1), 12'h013}, exp_wake(p));
      wr_reg({4'(p + 1), 12'h013}, 32'h4);
      rd_chk({4'(p + 1), 12'h013}, exp_wake(p) & 3'h3);
      wr_reg({4'(p + 1), 12'h013}, 32'hFF);
      rd_chk({4'(p + 1), 12'h013}, 32'h0);
      rd_chk(INT_STATUS_OFS, 32'h2 << p);
      #1 check("irq", 0, irq);
    end
    // Mid-run reset with a flag pending and tags written
    @(posedge mclk);
    pat[0] <= 1'h1;
    @(posedge mclk);
    pat[0] <= 1'h0;
    #1 check("wake_event", 9'h004, wev);
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    #1 check("wake_event", 9'h000, wev);
    check("port_vid", {3{12'h001}}, vid);
    rd_chk(CTRL_OFS, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
